// file: core/csd_pkg.sv
// *****************************************************************
// Store datapath constants, types and helpers
// *****************************************************************
package csd_pkg;

  // Word and address geometry, bit 0 is the sign position S
  localparam int WORD_W    = 36;
  localparam int ADDR_W    = 15;
  localparam int AF_LO     = 21;   // Address field low bit
  localparam int AF_HI     = 35;   // Address field high bit
  localparam int DF_LO     = 3;    // Decrement field low bit
  localparam int DF_HI     = 17;   // Decrement field high bit
  localparam int CHAR_W    = 6;
  localparam int CHAR_LAST = 5;    // Highest legal position code
  localparam int CHAR_SRC  = 30;   // First accumulator bit of a character

  localparam logic [ADDR_W-1:0] IC_STEP     = 15'h0001;
  localparam logic [ADDR_W-1:0] TRAP_LOC    = 15'h0000;
  localparam logic [ADDR_W-1:0] TRAP_VECTOR = 15'h0002;
  localparam logic              CHECK_ODD   = 1'h1;   // Odd word parity
  localparam logic [0:WORD_W-1] WORD_ZERO   = 36'h000000000;
  localparam logic [0:WORD_W-1] WORD_ONES   = 36'hfffffffff;

  // Store operation codes
  typedef enum logic [3:0] {
    OP_STORE_IC    = 4'b0000,
    OP_STORE_ADDR  = 4'b0001,
    OP_STORE_DECR  = 4'b0010,
    OP_STORE_ACC   = 4'b0011,
    OP_STORE_LOGIC = 4'b0100,
    OP_STORE_MQ    = 4'b0101,
    OP_STORE_ZERO  = 4'b0110,
    OP_STORE_TRAP  = 4'b0111,
    OP_STORE_CHAR  = 4'b1000,
    OP_STORE_CHAN  = 4'b1001
  } csd_op_e;

  typedef enum logic [2:0] {
    ST_IDLE  = 3'b000,
    ST_READ  = 3'b001,
    ST_FORM  = 3'b010,
    ST_WRITE = 3'b011,
    ST_DONE  = 3'b100
  } csd_state_e;

  // Ones over bits lo..hi of a word
  function automatic logic [0:WORD_W-1] csd_field_mask(input int lo, input int hi);
    logic [0:WORD_W-1] m;
    m = WORD_ZERO;
    for (int i = 0; i < WORD_W; i++)
      m[i] = (i >= lo) && (i <= hi);
    return m;
  endfunction

  // Address-width value placed in bits 21..35, zeros elsewhere
  function automatic logic [0:WORD_W-1] csd_place_addr(input logic [ADDR_W-1:0] a);
    logic [0:WORD_W-1] w;
    w = WORD_ZERO;
    w[AF_LO:AF_HI] = a;
    return w;
  endfunction

  // Character slot for a position code; codes 110 and 111 select nothing
  function automatic logic [0:WORD_W-1] csd_char_mask(input logic [2:0] c);
    logic [0:WORD_W-1] m;
    m = WORD_ZERO;
    if (int'(c) <= CHAR_LAST)
      m = csd_field_mask(CHAR_W * int'(c), CHAR_W * int'(c) + CHAR_W - 1);
    return m;
  endfunction

  // Check bit for a stored word
  function automatic logic csd_check(input logic [0:WORD_W-1] w);
    return (^w) ^ CHECK_ODD;
  endfunction

endpackage

// file: core/csd_word_merge.sv
`timescale 1ns/1ns
// *****************************************************************
// Storage bus word former
// *****************************************************************
module csd_word_merge
  import csd_pkg::*;
(
  input  wire logic [0:WORD_W-1] base_word,
  input  wire logic [0:WORD_W-1] insert_word,
  input  wire logic [0:WORD_W-1] insert_mask,
  input  wire logic              bus_block,
  output logic      [0:WORD_W-1] merged_word,
  output logic                   merged_check
);

  // Unchanged core bits joined with the new field
  wire logic [0:WORD_W-1] joined_w = (base_word & ~insert_mask) | (insert_word & insert_mask);

  // Blocking the register onto the bus leaves all zeros
  assign merged_word  = bus_block ? WORD_ZERO : joined_w;  // RULE_08
  // Recomputed so partial stores never leave a stale check bit
  assign merged_check = csd_check(merged_word);             // RULE_15

endmodule // csd_word_merge

// file: core/csd_store_path.sv
`timescale 1ns/1ns
// Behaviour
// (RULE_01) Stored counter value is the store instruction address plus one.
// (RULE_02) Counter goes to bits 21-35; bits S-20 keep the old core word.
// (RULE_03) Store address field replaces bits 21-35 with accumulator bits 21-35.
// (RULE_04) Store decrement field replaces bits 3-17 with accumulator bits 3-17.
// (RULE_05) Full accumulator store writes sign and bits 1-35 as one word.
// (RULE_06) Logical word store puts accumulator P in the sign position.
// (RULE_07) Multiplier-quotient store writes its whole word, S through 35.
// (RULE_08) Store zero blocks the storage register, leaving all zeros.
// (RULE_09) Trap store targets location zero with counter+1 over zeros.
// (RULE_10) Trap store ignores the effective address; location is implied.
// (RULE_11) After the trap store the counter loads octal 00002.
// (RULE_12) Character store inserts accumulator bits 30-35 at the selected slot.
// (RULE_13) Channel store drives word count to 3-17, address to 21-35.
// (RULE_14) Position codes 000 to 101 select six-bit slots S-5 to 30-35.
// (RULE_15) Check bit is regenerated for every written word.
module csd_store_path
  import csd_pkg::*;
(
  input  wire logic              clk,
  input  wire logic              rst_n,
  input  wire logic              req_valid,
  output logic                   req_ready,
  input  wire logic [3:0]        req_op,
  input  wire logic [ADDR_W-1:0] req_eff_addr,
  input  wire logic [ADDR_W-1:0] req_instr_addr,
  input  wire logic              acc_sign,
  input  wire logic              acc_p,
  input  wire logic [1:WORD_W-1] acc_mag,
  input  wire logic [0:WORD_W-1] multiplier_quotient_register,
  input  wire logic [2:0]        pos_code,
  input  wire logic [ADDR_W-1:0] chan_word_count,
  input  wire logic [ADDR_W-1:0] chan_addr,
  output logic [ADDR_W-1:0]      memory_address_latch,
  output logic                   mem_rd_req,
  input  wire logic              mem_rd_valid,
  input  wire logic [0:WORD_W-1] mem_rd_data,
  output logic                   mem_wr_req,
  output logic [0:WORD_W-1]      mem_wr_data,
  output logic                   mem_wr_check,
  input  wire logic              mem_wr_ack,
  output logic                   done,
  output logic                   ic_load,
  output logic [ADDR_W-1:0]      ic_load_value
);

  // *****************************************************************
  // Request decode
  // *****************************************************************

  csd_state_e        state_q, state_d;
  csd_op_e           op_q;
  logic [0:WORD_W-1] sreg_q, sreg_d;
  logic [0:WORD_W-1] mask_q, mask_d;
  logic [0:WORD_W-1] memory_read_latch;
  logic [0:WORD_W-1] wdata_q;
  logic              wcheck_q;
  logic [ADDR_W-1:0] addr_q;
  logic [ADDR_W-1:0] icv_q;
  logic [ADDR_W-1:0] vec_q;

  wire csd_op_e           op_in      = csd_op_e'(req_op);
  wire logic              accept     = req_valid && (state_q == ST_IDLE);
  wire logic [ADDR_W-1:0] ic_next    = req_instr_addr + IC_STEP;         // RULE_01
  wire logic [0:WORD_W-1] acc_word   = {acc_sign, acc_mag};              // RULE_05
  wire logic [0:WORD_W-1] logic_word = {acc_p, acc_mag};                 // RULE_06
  wire logic [0:WORD_W-1] af_mask    = csd_field_mask(AF_LO, AF_HI);
  wire logic [0:WORD_W-1] df_mask    = csd_field_mask(DF_LO, DF_HI);
  wire logic [0:WORD_W-1] chr_mask   = csd_char_mask(pos_code);         // RULE_14
  wire logic [0:WORD_W-1] chr_low    = WORD_W'(acc_mag[CHAR_SRC:WORD_W-1]);
  wire integer            chr_shift  = CHAR_W * (CHAR_LAST - int'(pos_code));
  wire logic [0:WORD_W-1] chr_word   = chr_low << chr_shift;             // RULE_12
  wire logic              is_trap    = (op_in == OP_STORE_TRAP);
  // Full stores other than the trap never need the old word
  wire logic              need_read  = !(op_in inside {OP_STORE_ACC, OP_STORE_LOGIC,
                                                       OP_STORE_MQ, OP_STORE_ZERO});

  // Storage register content and write mask per operation
  always_comb
  begin
    sreg_d = WORD_ZERO;
    mask_d = WORD_ONES;
    case (op_in)
      OP_STORE_IC:
      begin
        sreg_d = csd_place_addr(ic_next);     // RULE_02
        mask_d = af_mask;                     // RULE_02
      end
      OP_STORE_ADDR:
      begin
        sreg_d = acc_word;
        mask_d = af_mask;                     // RULE_03
      end
      OP_STORE_DECR:
      begin
        sreg_d = acc_word;
        mask_d = df_mask;                     // RULE_04
      end
      OP_STORE_ACC:   sreg_d = acc_word;      // RULE_05
      OP_STORE_LOGIC: sreg_d = logic_word;    // RULE_06
      OP_STORE_MQ:    sreg_d = multiplier_quotient_register;  // RULE_07
      OP_STORE_ZERO:  sreg_d = acc_word;      // Only the bus block zeroes it
      OP_STORE_TRAP:  sreg_d = csd_place_addr(ic_next);       // RULE_09
      OP_STORE_CHAR:
      begin
        sreg_d = chr_word;
        mask_d = chr_mask;                    // RULE_12
      end
      OP_STORE_CHAN:  mask_d = af_mask | df_mask;              // RULE_13
      default:
      begin
        sreg_d = WORD_ZERO;
        mask_d = WORD_ZERO;
      end
    endcase
  end

  // *****************************************************************
  // Word formation
  // *****************************************************************

  // Channel fields are formed on the bus, bypassing the storage register
  wire logic [0:WORD_W-1] chan_bus_w = {3'h0, chan_word_count, 3'h0, chan_addr};  // RULE_13
  wire logic              chan_op    = (op_q == OP_STORE_CHAN);
  wire logic [0:WORD_W-1] ins_w      = chan_op ? chan_bus_w : sreg_q;
  wire logic              block_w    = (op_q == OP_STORE_ZERO);    // RULE_08
  logic [0:WORD_W-1]      merged_w;
  logic                   merged_chk;

  csd_word_merge u_merge (
    .base_word    (memory_read_latch),
    .insert_word  (ins_w),
    .insert_mask  (mask_q),
    .bus_block    (block_w),
    .merged_word  (merged_w),
    .merged_check (merged_chk)
  );

  // *****************************************************************
  // Sequencer
  // *****************************************************************

  // Read (only when the old word is needed), form, write, then one cycle of completion
  always_comb
  begin
    state_d = state_q;
    case (state_q)
      ST_IDLE:  if (req_valid) state_d = need_read ? ST_READ : ST_FORM;
      ST_READ:  if (mem_rd_valid) state_d = ST_FORM;
      ST_FORM:  state_d = ST_WRITE;
      ST_WRITE: if (mem_wr_ack) state_d = ST_DONE;
      ST_DONE:  state_d = ST_IDLE;
      default:  state_d = ST_IDLE;
    endcase
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      state_q <= ST_IDLE;
    else
      state_q <= state_d;
  end

  // Operands captured when the request is taken
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      op_q   <= OP_STORE_IC;
      sreg_q <= WORD_ZERO;
      mask_q <= WORD_ZERO;
      addr_q <= TRAP_LOC;
      icv_q  <= TRAP_LOC;
    end
    else if (accept)
    begin
      op_q   <= op_in;
      sreg_q <= sreg_d;
      mask_q <= mask_d;
      // Trap store clears the address; the given address is not looked at
      addr_q <= is_trap ? TRAP_LOC : req_eff_addr;     // RULE_09 RULE_10
      icv_q  <= ic_next;                               // RULE_01
    end
  end

  // Old word off the storage bus; cleared for stores that skip the read
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      memory_read_latch <= WORD_ZERO;
    else if (accept)
      memory_read_latch <= WORD_ZERO;
    else if ((state_q == ST_READ) && mem_rd_valid)
      memory_read_latch <= mem_rd_data;                // RULE_02
  end

  // Write word and its check bit, held through the write
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      wdata_q  <= WORD_ZERO;
      wcheck_q <= 1'h0;
    end
    else if (state_q == ST_FORM)
    begin
      wdata_q  <= merged_w;
      wcheck_q <= merged_chk;                           // RULE_15
    end
  end

  // Next fetch address after a trap store
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      vec_q <= TRAP_LOC;
    else if ((state_q == ST_WRITE) && mem_wr_ack && (op_q == OP_STORE_TRAP))
      vec_q <= TRAP_VECTOR;                              // RULE_11
  end

  // *****************************************************************
  // Outputs
  // *****************************************************************

  assign req_ready            = (state_q == ST_IDLE);
  assign mem_rd_req           = (state_q == ST_READ);
  assign mem_wr_req           = (state_q == ST_WRITE);
  assign memory_address_latch = addr_q;
  assign mem_wr_data          = wdata_q;
  assign mem_wr_check         = wcheck_q;
  assign done                 = (state_q == ST_DONE);
  assign ic_load              = done && (op_q == OP_STORE_TRAP);  // RULE_11
  assign ic_load_value        = vec_q;

  // *****************************************************************
  // Checks
  // *****************************************************************

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  a_ic_plus_one: assert property (  // RULE_01
    accept && (op_in == OP_STORE_IC) |=> icv_q == $past(req_instr_addr) + IC_STEP)
    else $error("stored counter is not instruction address plus one");

  a_ic_keeps_old: assert property (  // RULE_02
    mem_wr_req && (op_q == OP_STORE_IC) |->
      (mem_wr_data[AF_LO:AF_HI] == icv_q) && (mem_wr_data[0:20] == memory_read_latch[0:20]))
    else $error("counter store merge wrong");

  a_addr_field: assert property (  // RULE_03
    mem_wr_req && (op_q == OP_STORE_ADDR) |->
      mem_wr_data == ((memory_read_latch & ~af_mask) | (sreg_q & af_mask)))
    else $error("address field store merge wrong");

  a_decr_field: assert property (  // RULE_04
    mem_wr_req && (op_q == OP_STORE_DECR) |->
      mem_wr_data == ((memory_read_latch & ~df_mask) | (sreg_q & df_mask)))
    else $error("decrement field store merge wrong");

  a_full_no_read: assert property (  // RULE_05
    accept && (op_in == OP_STORE_ACC) |=> (state_q == ST_FORM) ##1 mem_wr_data == $past(acc_word, 2))
    else $error("full accumulator store wrong");

  a_logic_sign: assert property (  // RULE_06
    accept && (op_in == OP_STORE_LOGIC) |=> ##1 mem_wr_data[0] == $past(acc_p, 2))
    else $error("logical store sign not from P");

  a_mq_word: assert property (  // RULE_07
    accept && (op_in == OP_STORE_MQ) |=> ##1 mem_wr_data == $past(multiplier_quotient_register, 2))
    else $error("multiplier-quotient store wrong");

  a_zero_word: assert property (  // RULE_08
    mem_wr_req && (op_q == OP_STORE_ZERO) |-> (mem_wr_data == WORD_ZERO))
    else $error("store zero wrote a nonzero word");

  a_trap_word: assert property (  // RULE_09
    mem_wr_req && (op_q == OP_STORE_TRAP) |->
      (memory_address_latch == TRAP_LOC) && (mem_wr_data == csd_place_addr(icv_q)))
    else $error("trap store location or word wrong");

  a_trap_vector: assert property (  // RULE_11
    mem_wr_req && mem_wr_ack && (op_q == OP_STORE_TRAP) |=> ic_load && (ic_load_value == TRAP_VECTOR))
    else $error("trap store did not load the vector");

  a_char_slot: assert property (  // RULE_12
    mem_wr_req && (op_q == OP_STORE_CHAR) |->
      (mem_wr_data & ~mask_q) == (memory_read_latch & ~mask_q))
    else $error("character store disturbed other bits");

  a_chan_fields: assert property (  // RULE_13
    (state_q == ST_FORM) && chan_op |=>
      (mem_wr_data[DF_LO:DF_HI] == $past(chan_word_count)) &&
      (mem_wr_data[AF_LO:AF_HI] == $past(chan_addr)))
    else $error("channel bus fields wrong");

  a_check_bit: assert property (  // RULE_15
    mem_wr_req |-> (mem_wr_check == ((^mem_wr_data) ^ CHECK_ODD)))
    else $error("check bit does not match written word");

  c_partial_store: cover property (accept && (op_in == OP_STORE_ADDR) ##[1:20] done);
  c_trap_store:    cover property (ic_load);
  c_char_last:     cover property (accept && (op_in == OP_STORE_CHAR) && (pos_code == 3'h5));
  c_chan_store:    cover property (mem_wr_req && chan_op);

endmodule // csd_store_path

// file: sim/csd_mem_model.sv
`timescale 1ns/1ns
// ************************************************
// Core storage partner on the storage bus
// ************************************************
module csd_mem_model
  import csd_pkg::*;
(
  input  wire logic              clk,
  input  wire logic              rst_n,
  input  wire logic [1:0]        dly,
  input  wire logic [ADDR_W-1:0] addr,
  input  wire logic              rd_req,
  output logic                   rd_valid,
  output logic      [0:WORD_W-1] rd_data,
  input  wire logic              wr_req,
  input  wire logic [0:WORD_W-1] wr_data,
  input  wire logic              wr_check,
  output logic                   wr_ack
);
  logic [0:WORD_W-1] mem [0:15];   // Only the low address bits decode
  logic              chk_q;
  logic [1:0]        cnt_q;
  wire               rd_go = rd_req && !rd_valid && (cnt_q >= dly);
  wire               wr_go = wr_req && !wr_ack && (cnt_q >= dly);

  // Slow or prompt answers; idle data toggles so stale bits never look valid
  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rd_valid <= 1'b0;
      wr_ack   <= 1'b0;
      cnt_q    <= 2'h0;
      rd_data  <= 36'h5a5a5a5a5;
    end
    else
    begin
      rd_valid <= rd_go;
      wr_ack   <= wr_go;
      rd_data  <= rd_go ? mem[addr[3:0]] : ~rd_data;
      if (rd_go || wr_go || !(rd_req || wr_req))
        cnt_q <= 2'h0;
      else
        cnt_q <= cnt_q + 2'h1;
      if (wr_go)
      begin
        mem[addr[3:0]] <= wr_data;
        chk_q          <= wr_check;
      end
    end
  end
endmodule // csd_mem_model

// file: sim/cpu_store_datapath_tb_top.sv
`timescale 1ns/1ns
// ************************************************
// Store datapath bench against the storage model
// ************************************************
module cpu_store_datapath_tb_top;
  import csd_pkg::*;
  logic              clk = 1'b0;
  logic              rst_n, req_valid, req_ready, acc_sign, acc_p, rd_req, rd_valid;
  logic              wr_req, wr_check, wr_ack, done, ic_load;
  logic [3:0]        req_op;
  logic [2:0]        pos_code;
  logic [1:0]        dly;
  logic [ADDR_W-1:0] eff, ia, wc, ca, mal, icv, ic_exp;
  logic [1:WORD_W-1] acc_mag;
  logic [0:WORD_W-1] mq, rd_data, wr_data;
  integer            seed, n_mismatch, comparisons;

  always #4 clk = ~clk;

  csd_store_path csd_store_path_inst (
    .clk(clk), .rst_n(rst_n), .req_valid(req_valid), .req_ready(req_ready),
    .req_op(req_op), .req_eff_addr(eff), .req_instr_addr(ia), .acc_sign(acc_sign),
    .acc_p(acc_p), .acc_mag(acc_mag), .multiplier_quotient_register(mq),
    .pos_code(pos_code), .chan_word_count(wc), .chan_addr(ca),
    .memory_address_latch(mal), .mem_rd_req(rd_req), .mem_rd_valid(rd_valid),
    .mem_rd_data(rd_data), .mem_wr_req(wr_req), .mem_wr_data(wr_data),
    .mem_wr_check(wr_check), .mem_wr_ack(wr_ack), .done(done), .ic_load(ic_load),
    .ic_load_value(icv));

  csd_mem_model csd_mem_model_inst (
    .clk(clk), .rst_n(rst_n), .dly(dly), .addr(mal), .rd_req(rd_req),
    .rd_valid(rd_valid), .rd_data(rd_data), .wr_req(wr_req), .wr_data(wr_data),
    .wr_check(wr_check), .wr_ack(wr_ack));

  // Random 36-bit word from the fixed seed
  function automatic logic [0:WORD_W-1] rw();
    logic [63:0] t;
    t = {$random(seed), $random(seed)};
    return t[35:0];
  endfunction

  // Word that core storage must hold after the store
  function automatic logic [0:WORD_W-1] expect_word(input logic [3:0] op,
    input logic [0:WORD_W-1] old, aw, mw, input logic p, input logic [2:0] pc,
    input logic [ADDR_W-1:0] iv, w, c);
    logic [0:WORD_W-1] r;
    r = old;
    case (op)
      4'h0: r[21:35] = iv + 15'h0001;
      4'h1: r[21:35] = aw[21:35];
      4'h2: r[3:17] = aw[3:17];
      4'h3: r = aw;
      4'h4: r = {p, aw[1:35]};
      4'h5: r = mw;
      4'h6: r = WORD_ZERO;
      4'h7: r = {21'h000000, iv + 15'h0001};
      4'h8: if (pc <= 3'h5)
              for (int i = 0; i < CHAR_W; i++)
                r[CHAR_W * int'(pc) + i] = aw[CHAR_SRC + i];
      4'h9: r = {old[0:2], w, old[18:20], c};
      default: r = old;
    endcase
    return r;
  endfunction

  task automatic check(input bit ok, input string what);
    comparisons++;
    if (!ok)
    begin
      n_mismatch++;
      $display("MISMATCH at %0t: %s", $time, what);
    end
  endtask

  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  // One store, memory paced by a random answer delay
  task automatic run_op(input logic [3:0] op, input logic [ADDR_W-1:0] ea,
    input logic [2:0] pc);
    logic [0:WORD_W-1] aw, mw, old, ex;
    logic [ADDR_W-1:0] a, iv, w, c;
    logic              p;
    int                n;
    aw = rw();
    mw = rw();
    old = rw();
    p = 1'($random(seed));
    iv = 15'($random(seed));
    w = 15'($random(seed));
    c = 15'($random(seed));
    a = (op == 4'h7) ? TRAP_LOC : ea;
    csd_mem_model_inst.mem[a[3:0]] = old;
    ex = expect_word(op, old, aw, mw, p, pc, iv, w, c);
    @(posedge clk);
    req_op <= op;
    eff <= ea;
    ia <= iv;
    acc_sign <= aw[0];
    acc_mag <= aw[1:35];
    acc_p <= p;
    mq <= mw;
    pos_code <= pc;
    wc <= w;
    ca <= c;
    dly <= 2'($random(seed));
    req_valid <= 1'b1;
    @(posedge clk);
    req_valid <= 1'b0;
    n = 0;
    do
    begin
      @(posedge clk);
      #1;
      n++;
      if (wr_req === 1'b1) check(mal === a, "store address");
    end
    while (done !== 1'b1 && n < 40);
    if (done !== 1'b1)
    begin
      n_mismatch++;
      $display("MISMATCH at %0t: no done", $time);
      complete_run();
    end
    check(csd_mem_model_inst.mem[a[3:0]] === ex, "stored word");
    check(csd_mem_model_inst.chk_q === ~^ex, "check bit");
    check(ic_load === (op == 4'h7), "counter load pulse");
    if (op == 4'h7)
      ic_exp = TRAP_VECTOR;
    check(icv === ic_exp, "counter load value");
    @(posedge clk);
    #1;
    check(done === 1'b0 && req_ready === 1'b1, "done pulse width");
    $display("test op %0d addr %0d finished", op, a);
  endtask

  // Reset, directed corners, random mix, reset in mid-run
  initial
  begin
    seed = 75;
    n_mismatch = 0;
    comparisons = 0;
    ic_exp = 15'h0000;
    {rst_n, req_valid, acc_sign, acc_p, req_op, pos_code, dly} = '0;
    {eff, ia, wc, ca, acc_mag, mq} = '0;
    @(posedge clk);
    #1;
    check(req_ready === 1'b1 && rd_req === 1'b0 && wr_req === 1'b0 && done === 1'b0, "reset");
    @(posedge clk);
    rst_n <= 1'b1;
    run_op(4'h0, 15'h0003, 3'h0);
    run_op(4'h1, 15'h7ff4, 3'h0);
    run_op(4'h2, 15'h0005, 3'h0);
    run_op(4'h3, 15'h0006, 3'h0);
    run_op(4'h4, 15'h0007, 3'h0);
    run_op(4'h5, 15'h0008, 3'h0);
    run_op(4'h6, 15'h0009, 3'h0);
    run_op(4'h7, 15'h1235, 3'h0);
    run_op(4'h9, 15'h000a, 3'h0);
    for (int k = 0; k < 8; k++)
      run_op(4'h8, 15'(k + 1), 3'(k));
    repeat (60)
      run_op(4'($unsigned($random(seed)) % 10), 15'($random(seed)), 3'($random(seed)));
    @(posedge clk);
    rst_n <= 1'b0;
    ic_exp = 15'h0000;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    #1;
    check(icv === ic_exp, "counter value after reset");
    run_op(4'h7, 15'h0004, 3'h0);
    complete_run();
  end
endmodule // cpu_store_datapath_tb_top
